//--- core/cmpd_pkg.sv
// package of constants and types for the compare instruction decoder
package cmpd_pkg;
    // ****************************************************************
    // opcode fields
    // ****************************************************************
    localparam logic [6:0] OPC_REG_W_B   = 7'h45;  // 1000101 W
    localparam logic [6:0] OPC_IR_W_B    = 7'h05;  // 0000101 W
    localparam logic [6:0] OPC_X_W_B     = 7'h25;  // 0100101 W
    localparam logic [6:0] OPC_CIM_IR    = 7'h06;  // 0000110 W
    localparam logic [6:0] OPC_CIM_X     = 7'h26;  // 0100110 W
    localparam logic [7:0] OPC_L_REG     = 8'h90;  // 10 010000
    localparam logic [7:0] OPC_L_IR      = 8'h10;  // 00 010000
    localparam logic [7:0] OPC_L_X       = 8'h50;  // 01 010000
    localparam logic [7:0] OPC_IM_W      = 8'h0b;
    localparam logic [7:0] OPC_IM_B      = 8'h0a;
    localparam logic [3:0] CIM_NIBBLE    = 4'h1;
    // ****************************************************************
    // flag positions in o_flags
    // ****************************************************************
    localparam int FLAG_C = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_S = 1;
    localparam int FLAG_V = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    // ****************************************************************
    // cycle counts
    // ****************************************************************
    localparam logic [4:0] CYC_R_WB      = 5'h04;
    localparam logic [4:0] CYC_R_L       = 5'h08;
    localparam logic [4:0] CYC_IM_WB     = 5'h07;
    localparam logic [4:0] CYC_IM_L      = 5'h0e;
    localparam logic [4:0] CYC_IR_WB     = 5'h07;
    localparam logic [4:0] CYC_IR_L      = 5'h0e;
    localparam logic [4:0] CYC_DA_NS_WB  = 5'h09;
    localparam logic [4:0] CYC_DA_SS_WB  = 5'h0a;
    localparam logic [4:0] CYC_DA_SL_WB  = 5'h0c;
    localparam logic [4:0] CYC_DA_NS_L   = 5'h0f;
    localparam logic [4:0] CYC_DA_SS_L   = 5'h10;
    localparam logic [4:0] CYC_DA_SL_L   = 5'h12;
    localparam logic [4:0] CYC_X_NS_WB   = 5'h0a;
    localparam logic [4:0] CYC_X_SS_WB   = 5'h0a;
    localparam logic [4:0] CYC_X_SL_WB   = 5'h0d;
    localparam logic [4:0] CYC_X_NS_L    = 5'h10;
    localparam logic [4:0] CYC_X_SS_L    = 5'h10;
    localparam logic [4:0] CYC_X_SL_L    = 5'h13;
    localparam logic [4:0] CYC_CI_IR     = 5'h0b;
    localparam logic [4:0] CYC_CI_DA_NS  = 5'h0e;
    localparam logic [4:0] CYC_CI_DA_SS  = 5'h0f;
    localparam logic [4:0] CYC_CI_DA_SL  = 5'h11;
    localparam logic [4:0] CYC_CI_X_NS   = 5'h0f;
    localparam logic [4:0] CYC_CI_X_SS   = 5'h0f;
    localparam logic [4:0] CYC_CI_X_SL   = 5'h12;
    localparam logic [4:0] CYC_ONE       = 5'h01;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } cmpd_size_type;
    typedef enum logic [2:0] {
        AM_REG,
        AM_LIT,
        AM_PTR,
        AM_DIR,
        AM_IDX
    } cmpd_mode_type;
endpackage : cmpd_pkg

//--- core/cmpd_core.sv
// compare instruction decoder and executor
`timescale 1ns/100ps
module cmpd_core (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_segmented,
    input  wire logic        i_word_valid,
    input  wire logic [15:0] i_word,
    input  wire logic [31:0] i_dst_val,
    input  wire logic [31:0] i_src_val,
    output logic             o_word_ready,
    output logic [3:0]       o_dst_reg,
    output logic [3:0]       o_src_reg,
    output logic             o_ptr_pair,
    output logic [1:0]       o_size,
    output logic [2:0]       o_mode,
    output logic [3:0]       o_flags,
    output logic             o_done,
    output logic             o_illegal
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_OPC,
        ST_EXT,
        ST_EXEC
    } cmpd_state_type;

    cmpd_state_type state_q;
    logic [15:0]    opc_q;
    logic [1:0]     ext_left_q;
    logic           ext_first_q;
    logic           long_seg_q;
    logic [4:0]     cyc_q;
    logic [4:0]     cnt_q;
    logic [3:0]     flags_q;
    logic           done_q;
    logic           ill_q;
    logic [15:0]    imm_q;
    logic           cim_q;
    logic [1:0]     size_q;
    logic [2:0]     mode_q;

    // ****************************************************************
    // decode of the first word
    // ****************************************************************
    logic [6:0]  top7;
    logic [7:0]  top8;
    logic [3:0]  fa;
    logic [3:0]  fb;
    logic        wbit;
    logic        legal;
    logic        is_cim;
    logic [1:0]  dsz;
    logic [2:0]  dmode;
    logic [1:0]  dext;
    logic [4:0]  dcyc;

    assign top7 = i_word[15:9];
    assign top8 = i_word[15:8];
    assign fa   = i_word[7:4];
    assign fb   = i_word[3:0];
    assign wbit = i_word[8];

    always_comb begin
        legal  = 1'b1;
        is_cim = 1'b0;
        dsz    = wbit ? 2'(cmpd_pkg::SZ_WORD) : 2'(cmpd_pkg::SZ_BYTE);
        dmode  = 3'(cmpd_pkg::AM_REG);
        dext   = 2'h0;
        dcyc   = cmpd_pkg::CYC_R_WB;
        if (top7 == cmpd_pkg::OPC_REG_W_B) begin
            dcyc = cmpd_pkg::CYC_R_WB;
        end else if (top8 == cmpd_pkg::OPC_L_REG) begin
            dsz  = 2'(cmpd_pkg::SZ_LONG);
            dcyc = cmpd_pkg::CYC_R_L;
        end else if ((top8 == cmpd_pkg::OPC_IM_W || top8 == cmpd_pkg::OPC_IM_B)
                     && fa == 4'h0) begin
            dsz   = top8[0] ? 2'(cmpd_pkg::SZ_WORD) : 2'(cmpd_pkg::SZ_BYTE);
            dmode = 3'(cmpd_pkg::AM_LIT);
            dext  = 2'h1;
            dcyc  = cmpd_pkg::CYC_IM_WB;
        end else if (top7 == cmpd_pkg::OPC_CIM_IR && fb == cmpd_pkg::CIM_NIBBLE
                     && fa != 4'h0) begin
            is_cim = 1'b1;
            dmode  = 3'(cmpd_pkg::AM_PTR);
            dext   = 2'h1;
            dcyc   = cmpd_pkg::CYC_CI_IR;
        end else if (top7 == cmpd_pkg::OPC_IR_W_B && fa != 4'h0) begin
            dmode = 3'(cmpd_pkg::AM_PTR);
            dcyc  = cmpd_pkg::CYC_IR_WB;
        end else if (top8 == cmpd_pkg::OPC_L_IR) begin
            dsz   = 2'(cmpd_pkg::SZ_LONG);
            dmode = (fa == 4'h0) ? 3'(cmpd_pkg::AM_LIT) : 3'(cmpd_pkg::AM_PTR);
            dext  = (fa == 4'h0) ? 2'h2 : 2'h0;
            dcyc  = (fa == 4'h0) ? cmpd_pkg::CYC_IM_L : cmpd_pkg::CYC_IR_L;
        end else if (top7 == cmpd_pkg::OPC_X_W_B || top8 == cmpd_pkg::OPC_L_X
                     || (top7 == cmpd_pkg::OPC_CIM_X && fb == cmpd_pkg::CIM_NIBBLE)) begin
            is_cim = (top7 == cmpd_pkg::OPC_CIM_X);
            if (top8 == cmpd_pkg::OPC_L_X) begin
                dsz = 2'(cmpd_pkg::SZ_LONG);
            end
            dmode = (fa == 4'h0) ? 3'(cmpd_pkg::AM_DIR) : 3'(cmpd_pkg::AM_IDX);
            // compare-immediate forms carry a data word after the address
            dext  = is_cim ? 2'h2 : 2'h1;
        end else begin
            legal = 1'b0;
        end
    end

    // address-mode cycle count once segment form is known
    function automatic logic [4:0] addr_cycles(input logic [2:0] md, input logic [1:0] sz,
                                               input logic ci, input logic seg,
                                               input logic sl);
        logic [4:0] c;
        c = cmpd_pkg::CYC_DA_NS_WB;
        if (ci) begin
            if (md == 3'(cmpd_pkg::AM_DIR)) begin
                c = !seg ? cmpd_pkg::CYC_CI_DA_NS
                  : (sl ? cmpd_pkg::CYC_CI_DA_SL : cmpd_pkg::CYC_CI_DA_SS);
            end else begin
                c = !seg ? cmpd_pkg::CYC_CI_X_NS
                  : (sl ? cmpd_pkg::CYC_CI_X_SL : cmpd_pkg::CYC_CI_X_SS);
            end
        end else if (sz == 2'(cmpd_pkg::SZ_LONG)) begin
            if (md == 3'(cmpd_pkg::AM_DIR)) begin
                c = !seg ? cmpd_pkg::CYC_DA_NS_L
                  : (sl ? cmpd_pkg::CYC_DA_SL_L : cmpd_pkg::CYC_DA_SS_L);
            end else begin
                c = !seg ? cmpd_pkg::CYC_X_NS_L
                  : (sl ? cmpd_pkg::CYC_X_SL_L : cmpd_pkg::CYC_X_SS_L);
            end
        end else begin
            if (md == 3'(cmpd_pkg::AM_DIR)) begin
                c = !seg ? cmpd_pkg::CYC_DA_NS_WB
                  : (sl ? cmpd_pkg::CYC_DA_SL_WB : cmpd_pkg::CYC_DA_SS_WB);
            end else begin
                c = !seg ? cmpd_pkg::CYC_X_NS_WB
                  : (sl ? cmpd_pkg::CYC_X_SL_WB : cmpd_pkg::CYC_X_SS_WB);
            end
        end
        return c;
    endfunction : addr_cycles

    // ****************************************************************
    // compare arithmetic
    // ****************************************************************
    logic [31:0] dst_op;
    logic [31:0] src_op;
    logic [32:0] sum;
    logic        nflag;
    logic        zflag;
    logic        vflag;
    logic        cflag;
    logic [31:0] src_raw;

    always_comb begin
        src_raw = cim_q ? {imm_q, imm_q} : i_src_val;
        if (size_q == 2'(cmpd_pkg::SZ_BYTE)) begin
            dst_op = {i_dst_val[7:0], 24'h000000};
            src_op = {src_raw[7:0], 24'h000000};
        end else if (size_q == 2'(cmpd_pkg::SZ_WORD)) begin
            dst_op = {i_dst_val[15:0], 16'h0000};
            src_op = {src_raw[15:0], 16'h0000};
        end else begin
            dst_op = i_dst_val;
            src_op = src_raw;
        end
        sum   = {1'b0, dst_op} + {1'b0, ~src_op} + 33'h000000001;
        nflag = sum[31];
        zflag = (sum[31:0] == 32'h00000000);
        cflag = ~sum[32];
        vflag = (dst_op[31] != src_op[31]) && (sum[31] != dst_op[31]);
    end

    // ****************************************************************
    // fetch handshake
    // ****************************************************************
    logic        take;
    logic        long_first;
    logic        ext_last;
    logic        exec_end;
    logic        ready_d;

    // a word is taken only when ready shows it, so memory and decoder agree
    assign take       = i_word_valid && o_word_ready;
    assign long_first = ext_first_q && i_segmented && i_word[15]
                        && (mode_q == 3'(cmpd_pkg::AM_DIR) || mode_q == 3'(cmpd_pkg::AM_IDX));
    assign ext_last   = (ext_left_q == 2'h1) && !long_first;
    assign exec_end   = (cnt_q >= cyc_q - 5'h01);

    // ready follows the next state, low exactly while executing
    always_comb begin
        ready_d = 1'b1;
        case (state_q)
            ST_OPC:  ready_d = !(take && legal && dext == 2'h0);
            ST_EXT:  ready_d = !(take && ext_last);
            ST_EXEC: ready_d = exec_end;
            default: ready_d = 1'b1;
        endcase
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_q     <= ST_OPC;
            opc_q       <= 16'h0000;
            ext_left_q  <= 2'h0;
            ext_first_q <= 1'b0;
            long_seg_q  <= 1'b0;
            cyc_q       <= cmpd_pkg::CYC_ONE;
            cnt_q       <= cmpd_pkg::CYC_ONE;
            imm_q       <= 16'h0000;
            cim_q       <= 1'b0;
            size_q      <= 2'h0;
            mode_q      <= 3'h0;
            ill_q       <= 1'b0;
        end else begin
            ill_q <= 1'b0;
            case (state_q)
                ST_OPC: begin
                    cnt_q <= cmpd_pkg::CYC_ONE;
                    if (take) begin
                        opc_q       <= i_word;
                        size_q      <= dsz;
                        mode_q      <= dmode;
                        cim_q       <= is_cim;
                        cyc_q       <= dcyc;
                        ext_first_q <= 1'b1;
                        long_seg_q  <= 1'b0;
                        ext_left_q  <= dext;
                        ill_q       <= ~legal;
                        if (legal) begin
                            state_q <= (dext == 2'h0) ? ST_EXEC : ST_EXT;
                        end
                    end
                end
                ST_EXT: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (take) begin
                        ext_first_q <= 1'b0;
                        if ((mode_q == 3'(cmpd_pkg::AM_DIR) || mode_q == 3'(cmpd_pkg::AM_IDX))
                            && ext_first_q) begin
                            long_seg_q <= i_segmented && i_word[15];
                            cyc_q <= addr_cycles(mode_q, size_q, cim_q, i_segmented,
                                                 i_segmented && i_word[15]);
                        end
                        // last word of a compare-immediate is its data
                        if (cim_q) begin
                            imm_q <= i_word;
                        end
                        // long segment form keeps the count for the offset word
                        if (!long_first) begin
                            ext_left_q <= ext_left_q - 2'h1;
                        end
                        if (ext_last) begin
                            state_q <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (exec_end) begin
                        state_q <= ST_OPC;
                    end
                end
                default: state_q <= ST_OPC;
            endcase
        end
    end

    // ****************************************************************
    // flags: only effect of a compare
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flags_q <= cmpd_pkg::FLAGS_RESET;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (state_q == ST_EXEC && cnt_q >= cyc_q - 5'h01) begin
                flags_q[cmpd_pkg::FLAG_C] <= cflag;
                flags_q[cmpd_pkg::FLAG_Z] <= zflag;
                flags_q[cmpd_pkg::FLAG_S] <= nflag;
                flags_q[cmpd_pkg::FLAG_V] <= vflag;
                done_q  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_word_ready <= 1'b0;
            o_dst_reg    <= 4'h0;
            o_src_reg    <= 4'h0;
            o_ptr_pair   <= 1'b0;
        end else begin
            o_word_ready <= ready_d;
            o_dst_reg    <= cim_q ? opc_q[7:4] : opc_q[3:0];
            o_src_reg    <= opc_q[7:4];
            o_ptr_pair   <= i_segmented;
        end
    end

    assign o_size    = size_q;
    assign o_mode    = mode_q;
    assign o_flags   = flags_q;
    assign o_done    = done_q;
    assign o_illegal = ill_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_CARRY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done_q |-> flags_q[cmpd_pkg::FLAG_C] == $past(cflag)) else $error("carry wrong");
    AST_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done_q |-> flags_q[cmpd_pkg::FLAG_Z] == $past(zflag)) else $error("zero wrong");
    AST_NEG: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (done_q && flags_q[cmpd_pkg::FLAG_S] && !flags_q[cmpd_pkg::FLAG_V])
        |-> !flags_q[cmpd_pkg::FLAG_Z]) else $error("sign with zero");
    AST_FLAGS_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !done_q |-> $stable(flags_q)) else $error("flags moved");
    AST_CIM_EXEC: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_q == ST_EXEC && cim_q && mode_q == 3'(cmpd_pkg::AM_PTR))
        |-> cyc_q == cmpd_pkg::CYC_CI_IR) else $error("pointer compare not 11");
    AST_XL_NS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_q == ST_EXEC && !cim_q && !i_segmented && mode_q == 3'(cmpd_pkg::AM_IDX)
         && size_q == 2'(cmpd_pkg::SZ_LONG)) |-> cyc_q == cmpd_pkg::CYC_X_NS_L)
        else $error("long indexed not 16");
    AST_XL_SL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_q == ST_EXEC && !cim_q && long_seg_q && mode_q == 3'(cmpd_pkg::AM_IDX)
         && size_q == 2'(cmpd_pkg::SZ_LONG)) |-> cyc_q == cmpd_pkg::CYC_X_SL_L)
        else $error("long indexed seg not 19");
    AST_XWB_SS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state_q == ST_EXEC && !cim_q && i_segmented && !long_seg_q
         && mode_q == 3'(cmpd_pkg::AM_IDX) && size_q != 2'(cmpd_pkg::SZ_LONG))
        |-> cyc_q == cmpd_pkg::CYC_X_SS_WB) else $error("short indexed not 10");
    AST_PAIR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ##1 o_ptr_pair == $past(i_segmented)) else $error("pointer pair wrong");
    COV_DONE: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) done_q);
    COV_BORROW: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done_q && flags_q[cmpd_pkg::FLAG_C]);
    COV_LONGSEG: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done_q && long_seg_q);
endmodule : cmpd_core

//--- tb/cmpd_prog_mem.sv
// program memory model feeding instruction words to the decoder
`timescale 1ns/100ps
module cmpd_prog_mem (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_load,
    input  wire logic        i_slow,
    input  wire logic [1:0]  i_count,
    input  wire logic [15:0] i_w0,
    input  wire logic [15:0] i_w1,
    input  wire logic [15:0] i_w2,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [15:0]      o_word
);
    // ****************************************************************
    // word sequencing
    // ****************************************************************
    logic [1:0]  ptr_q;
    logic [1:0]  cnt_q;
    logic        gap_q;
    logic [15:0] last_q;
    logic [15:0] sel;

    always_comb begin
        sel = (ptr_q == 2'h0) ? i_w0 : (ptr_q == 2'h1) ? i_w1 : i_w2;
        o_valid = (ptr_q < cnt_q) && !(i_slow && gap_q);
        // idle bus shows the inverse of the last word, never a stale copy
        o_word = o_valid ? sel : ~last_q;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ptr_q  <= 2'h0;
            cnt_q  <= 2'h0;
            gap_q  <= 1'b0;
            last_q <= 16'h0000;
        end else begin
            gap_q <= ~gap_q;
            if (i_load) begin
                ptr_q <= 2'h0;
                cnt_q <= i_count;
            end else if (o_valid && i_ready) begin
                ptr_q  <= ptr_q + 2'h1;
                last_q <= sel;
            end
        end
    end
endmodule : cmpd_prog_mem

//--- tb/tb_compare_instruction_decode.sv
// self-checking testbench of the compare instruction decoder
`timescale 1ns/100ps
module tb_compare_instruction_decode;
    logic i_ref_clk, i_rst_n, i_segmented, i_word_valid, o_word_ready, o_ptr_pair;
    logic o_done, o_illegal, ld, slow;
    logic [15:0] i_word, w0, w1, w2;
    logic [31:0] i_dst_val, i_src_val;
    logic [3:0]  o_dst_reg, o_src_reg, o_flags;
    logic [1:0]  o_size, cnt;
    logic [2:0]  o_mode;
    int n_errors = 0;
    int n_tests = 0;

    cmpd_core dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_segmented(i_segmented),
        .i_word_valid(i_word_valid), .i_word(i_word), .i_dst_val(i_dst_val),
        .i_src_val(i_src_val), .o_word_ready(o_word_ready), .o_dst_reg(o_dst_reg),
        .o_src_reg(o_src_reg), .o_ptr_pair(o_ptr_pair), .o_size(o_size), .o_mode(o_mode),
        .o_flags(o_flags), .o_done(o_done), .o_illegal(o_illegal));
    cmpd_prog_mem mem_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_load(ld),
        .i_slow(slow), .i_count(cnt), .i_w0(w0), .i_w1(w1), .i_w2(w2),
        .i_ready(o_word_ready), .o_valid(i_word_valid), .o_word(i_word));

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [3:0] exp_flags(input logic [1:0] sz, input logic [31:0] d,
                                             input logic [31:0] s);
        logic [31:0] dd, ss, rr;
        int sh;
        sh = (sz == 2'h0) ? 24 : (sz == 2'h1) ? 16 : 0;
        dd = d << sh;
        ss = s << sh;
        rr = dd + ~ss + 32'h1;
        return {ss > dd, rr == 32'h0, rr[31], (dd[31] != ss[31]) && (rr[31] != dd[31])};
    endfunction : exp_flags

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic run(input logic seg, input logic [1:0] n, input logic [15:0] a,
                       input logic [15:0] b, input logic [15:0] c, input logic [31:0] d,
                       input logic [31:0] s, input logic [1:0] sz, input logic [2:0] md,
                       input int cyc, input logic sl);
        int k;
        @(posedge i_ref_clk);
        i_segmented <= seg;
        i_dst_val <= d;
        i_src_val <= s;
        slow <= sl;
        {w0, w1, w2} <= {a, b, c};
        cnt <= n;
        ld <= 1'b1;
        @(posedge i_ref_clk);
        ld <= 1'b0;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            k++;
        end while (o_done !== 1'b1 && k < 80);
        if (k >= 80) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, k, 1);
            test_done();
        end
        if (!sl) chk(k, cyc);
        chk(o_src_reg, a[7:4]);
        chk(o_dst_reg, (a[15:9] == cmpd_pkg::OPC_CIM_IR) ? a[7:4] : a[3:0]);
        chk(o_flags, exp_flags(sz, d, s));
        chk(o_size, sz);
        chk(o_mode, md);
        if (md == cmpd_pkg::AM_PTR) chk(o_ptr_pair, seg);
        $display("test done at %0t", $time);
        repeat (2) @(posedge i_ref_clk);
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] d, s;
        logic [1:0]  sz;
        int k;
        {i_rst_n, i_segmented, ld, slow, cnt, w0, w1, w2} = '0;
        {i_dst_val, i_src_val} = '0;
        void'($urandom(32'h0a82e671));
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        // pointer compare-immediate, word, both modes
        run(1'b0, 2'h2, 16'h0d51, 16'h1234, 16'h0, 32'h1234, 32'h1234, 2'h1,
            cmpd_pkg::AM_PTR, 11, 1'b0);
        run(1'b1, 2'h2, 16'h0d61, 16'h8001, 16'h0, 32'h0001, 32'h8001, 2'h1,
            cmpd_pkg::AM_PTR, 11, 1'b0);
        // byte at pointer 2 against immediate 3: borrow and negative
        run(1'b0, 2'h2, 16'h0c51, 16'h0303, 16'h0, 32'h02, 32'h03, 2'h0,
            cmpd_pkg::AM_PTR, 11, 1'b0);
        chk(o_flags, 4'ha);
        // long indexed, nonsegmented then long segment form
        run(1'b0, 2'h2, 16'h5034, 16'h0400, 16'h0, 32'h7fffffff, 32'hffffffff, 2'h2,
            cmpd_pkg::AM_IDX, 16, 1'b0);
        run(1'b1, 2'h3, 16'h5034, 16'h8500, 16'h0010, 32'h80000000, 32'h1, 2'h2,
            cmpd_pkg::AM_IDX, 19, 1'b0);
        // short segment form, word and byte
        run(1'b1, 2'h2, 16'h4b32, 16'h0510, 16'h0, 32'h8000, 32'h0001, 2'h1,
            cmpd_pkg::AM_IDX, 10, 1'b0);
        run(1'b1, 2'h2, 16'h4a32, 16'h0510, 16'h0, 32'h80, 32'h01, 2'h0,
            cmpd_pkg::AM_IDX, 10, 1'b0);
        // zero index field falls back to direct address
        run(1'b0, 2'h2, 16'h4b02, 16'h0400, 16'h0, 32'h5, 32'h5, 2'h1,
            cmpd_pkg::AM_DIR, 9, 1'b0);
        // slow memory still completes
        run(1'b0, 2'h2, 16'h0d51, 16'h00ff, 16'h0, 32'h0100, 32'h00ff, 2'h1,
            cmpd_pkg::AM_PTR, 11, 1'b1);
        // random register compares
        for (int i = 0; i < 12; i++) begin
            sz = 2'($urandom_range(0, 2));
            d = $urandom;
            s = (i == 0) ? d : $urandom;
            if (sz == 2'h2)
                run(1'b0, 2'h1, {8'h90, 4'h2, 4'h4}, 16'h0, 16'h0, d, s, sz,
                    cmpd_pkg::AM_REG, 8, 1'b0);
            else
                run(1'b0, 2'h1, {7'h45, sz[0], 4'h1, 4'h3}, 16'h0, 16'h0, d, s, sz,
                    cmpd_pkg::AM_REG, 4, 1'b0);
        end
        // first word that is no compare
        @(posedge i_ref_clk);
        {w0, cnt, ld} <= {16'hffff, 2'h1, 1'b1};
        @(posedge i_ref_clk);
        ld <= 1'b0;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            k++;
        end while (o_illegal !== 1'b1 && k < 10);
        chk(o_illegal, 1'b1);
        $display("test done at %0t", $time);
        test_done();
    end
endmodule : tb_compare_instruction_decode
